//--- logic/dacc_defines.svh
// Register offsets, field positions and reset values of the converter control
`ifndef DACC_DEFINES_SVH
`define DACC_DEFINES_SVH

`define DACC_CTRL_OFFSET      12'h000
`define DACC_DATA_OFFSET      12'h004
`define DACC_STAT_OFFSET      12'h008
`define DACC_ADDR_MSB         11

`define DACC_CTRL_RESET       16'h0000
`define DACC_DATA_RESET       16'h0000
`define DACC_CTRL_WMASK       16'hBBFF

`define DACC_BIT_ENABLE       15
`define DACC_BIT_SIDL         13
`define DACC_BIT_SLEEP        12
`define DACC_BIT_JUSTIFY      11
`define DACC_BIT_SOFT_RESET_DISABLE        9
`define DACC_BIT_TRIG         8
`define DACC_BIT_OE           7
`define DACC_TSEL_MSB         6
`define DACC_TSEL_LSB         2
`define DACC_REF_MSB          1
`define DACC_REF_LSB          0

`define DACC_CODE_RESET       8'h00
`define DACC_ZERO32           32'h0000_0000

`endif

//--- logic/dacc_pkg.sv
// Types shared by the converter control logic
package dacc_pkg;

    // Fields of the control register
    typedef struct packed {
        logic       converter_enable;
        logic       unused14;
        logic       stop_in_idle;
        logic       run_in_sleep;
        logic       data_justify_select;
        logic       unused10;
        logic       soft_reset_disable;
        logic       trigger_update_enable;
        logic       output_pin_enable;
        logic [4:0] trigger_source_select;
        logic [1:0] reference_select;
    } dacc_ctrl_s;

    // Power state of the converter
    typedef enum logic [2:0] {
        DACC_OFF    = 3'b001,
        DACC_RUN    = 3'b010,
        DACC_HALTED = 3'b100
    } dacc_state_e;

endpackage

//--- logic/dacc_control.sv
// Converter control logic with APB register access
// Register map (byte offsets, one aligned 32-bit word each)
//   0x000  control word; bits 14 and 10 always read as zero
//   0x004  data word; the justify bit picks the byte that is used
//   0x008  status, read only: [7:0] held code, [10:8] power state
//   other  answered with pslverr; writes dropped, reads give zero
//
// Bus timing
//   pready is tied high, so each transfer is one setup cycle and one
//   access cycle. Read data is loaded at the setup edge and stands
//   through the access phase until the next read setup.
//
// Resets
//   nrst is the power-on and brown-out reset and clears everything.
//   soft_reset stands for every other device reset. It clears the
//   control, data and code registers only while soft-reset-disable is
//   clear; the power state follows the cleared enable one edge later.
//
// Pin
//   While the converter drives its pin the port driver is held off.
//   Otherwise the port direction and latch bits own the pin again.
`include "dacc_defines.svh"

module dacc_control
    import dacc_pkg::*;
#(
    parameter int CODE_W = 8
) (
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              soft_reset,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    input  wire logic              idle_mode,
    input  wire logic              sleep_mode,
    input  wire logic [31:0]       trigger_events,
    input  wire logic              port_direction_bits,
    input  wire logic              port_latch_bits,
    output logic [CODE_W-1:0]      converter_code,
    output logic                   converter_active,
    output logic [4:0]             trigger_source_out,
    output logic [1:0]             reference_out,
    output logic                   analog_output_pin_o,
    output logic                   analog_output_pin_oe,
    output logic                   analog_output_to_pin,
    output logic                   internal_output_valid
);

    dacc_ctrl_s          ctrl_reg, ctrl_next;
    logic [15:0]         data_reg, data_next;
    logic [CODE_W-1:0]   code_reg, code_next;
    dacc_state_e         state_reg, state_next;
    logic                access;
    logic                wr_ctrl;
    logic                wr_data;
    logic                rd_hit;
    logic [15:0]         ctrl_bits;
    logic [15:0]         wdata16;
    logic                reg_clear;
    logic                trig_hit;
    logic [CODE_W-1:0]   picked;
    logic [31:0]         rdata_next;
    logic                halt_now;

    // Byte-lane merge of a 16-bit register with write data
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  st);
        merge16 = {st[1] ? wd[15:8] : old[15:8],
                   st[0] ? wd[7:0]  : old[7:0]};
    endfunction

    // Register hit on one offset; shared by the write and read decodes
    function automatic logic reg_hit(input logic [11:0] addr,
                                     input logic [11:0] offset);
        reg_hit = (addr == offset);
    endfunction

    // Halt condition shared by the running and halted states
    function automatic logic halt_req(input dacc_ctrl_s c,
                                      input logic       idle,
                                      input logic       sleep);
        halt_req = (idle && c.stop_in_idle) ||
                   (sleep && !c.run_in_sleep);
    endfunction

    // Address decode for the APB slave, zero-wait answer
    assign access    = psel & penable;
    assign pready    = 1'b1;
    // Writes land only at the access edge; the status word is read only
    assign wr_ctrl   = access & pwrite & reg_hit(paddr, `DACC_CTRL_OFFSET);
    assign wr_data   = access & pwrite & reg_hit(paddr, `DACC_DATA_OFFSET);
    assign rd_hit    = reg_hit(paddr, `DACC_CTRL_OFFSET) |
                       reg_hit(paddr, `DACC_DATA_OFFSET) |
                       reg_hit(paddr, `DACC_STAT_OFFSET);
    assign pslverr   = access & ~rd_hit;
    assign ctrl_bits = ctrl_reg;

    // Soft resets spare the registers while soft-reset-disable is set.
    // The bit does not guard itself: a control write clears it as well as
    // nrst; while it is set, a supervisor reset cannot glitch a running output.
    assign reg_clear = soft_reset & ~ctrl_reg.soft_reset_disable;

    // Selected trigger event, fields stored without decode.
    // The select indexes the event bus directly; which event sits on
    // which bit is up to the integration of the block.
    assign trig_hit  = trigger_events[ctrl_reg.trigger_source_select];

    // Justification picks the byte that feeds the converter
    always_comb begin
        picked = ctrl_reg.data_justify_select ? data_reg[15:8]
                                              : data_reg[7:0];
    end

    // Next register values
    always_comb begin
        ctrl_next = ctrl_reg;
        data_next = data_reg;
        wdata16   = merge16(ctrl_bits, pwdata, pstrb)
                    & `DACC_CTRL_WMASK;
        if (reg_clear) begin
            ctrl_next = `DACC_CTRL_RESET;
            data_next = `DACC_DATA_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_next = wdata16;
            end
            if (wr_data) begin
                data_next = merge16(data_reg, pwdata, pstrb);
            end
        end
    end

    // Register the control and data words
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ctrl_reg <= `DACC_CTRL_RESET;
            data_reg <= `DACC_DATA_RESET;
        end else begin
            ctrl_reg <= ctrl_next;
            data_reg <= data_next;
        end
    end

    // Halt request from Idle or Sleep under the current control word
    assign halt_now = halt_req(ctrl_reg, idle_mode, sleep_mode);

    // Power state: off, running, or halted by Idle or Sleep.
    // The state lags the enable by one edge, so a write that enables
    // the converter gives a running state at the following edge.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            DACC_OFF: begin
                if (ctrl_reg.converter_enable) begin
                    state_next = DACC_RUN;
                end
            end
            DACC_RUN: begin
                if (!ctrl_reg.converter_enable) begin
                    state_next = DACC_OFF;
                end else if (halt_now) begin
                    state_next = DACC_HALTED;
                end
            end
            DACC_HALTED: begin
                if (!ctrl_reg.converter_enable) begin
                    state_next = DACC_OFF;
                end else if (!halt_now) begin
                    state_next = DACC_RUN;
                end
            end
            default: begin
                state_next = DACC_OFF;
            end
        endcase
    end

    // Output code: immediate on data write or on trigger event.
    // Nothing but a soft reset loads while the converter is halted or in Sleep, so the
    // last code stands; a data write in that time is kept in the data
    // register and, with trigger updates enabled, used by the next trigger.
    always_comb begin
        code_next = code_reg;
        if (reg_clear) begin
            code_next = `DACC_CODE_RESET;
        end else if (state_reg == DACC_RUN && !sleep_mode) begin
            if (ctrl_reg.trigger_update_enable) begin
                if (trig_hit) begin
                    code_next = picked;
                end
            end else if (wr_data) begin
                code_next = ctrl_reg.data_justify_select
                          ? data_next[15:8] : data_next[7:0];
            end
        end
    end

    // State and held output code; Sleep with run_in_sleep holds code
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_reg <= DACC_OFF;
            code_reg  <= `DACC_CODE_RESET;
        end else begin
            state_reg <= state_next;
            code_reg  <= code_next;
        end
    end

    // Read data mux, loaded at the setup cycle of a read; the status
    // word holds the code in its low byte and the state above it
    always_comb begin
        rdata_next = prdata;
        if (psel && !penable && !pwrite) begin
            if (reg_hit(paddr, `DACC_CTRL_OFFSET)) begin
                rdata_next = 32'(ctrl_bits);
            end else if (reg_hit(paddr, `DACC_DATA_OFFSET)) begin
                rdata_next = 32'(data_reg);
            end else if (reg_hit(paddr, `DACC_STAT_OFFSET)) begin
                rdata_next = 32'({state_reg, code_reg});
            end else begin
                rdata_next = `DACC_ZERO32;
            end
        end
    end

    // Register the read data; it stands until the next read setup
    always_ff @(posedge clk) begin
        if (!nrst) begin
            prdata <= `DACC_ZERO32;
        end else begin
            prdata <= rdata_next;
        end
    end

    // Converter outputs and pin control.
    // The converter counts as active while running, and also while
    // Sleep holds its last code with run_in_sleep set; internal
    // consumers see the same flag whether or not the pin is driven.
    assign converter_code        = code_reg;
    assign converter_active      = (state_reg == DACC_RUN) |
                                   ((state_reg != DACC_OFF) & sleep_mode &
                                    ctrl_reg.run_in_sleep);
    assign trigger_source_out    = ctrl_reg.trigger_source_select;
    assign reference_out         = ctrl_reg.reference_select;
    assign internal_output_valid = converter_active;
    assign analog_output_to_pin  = converter_active &
                                   ctrl_reg.output_pin_enable;
    // Pin falls back to port direction and latch when not driven
    assign analog_output_pin_oe  = analog_output_to_pin ? 1'b0
                                   : ~port_direction_bits;
    assign analog_output_pin_o   = port_latch_bits;

endmodule // dacc_control

//--- dv/dacc_properties.sv
// Port assertions for the converter control block
`include "dacc_defines.svh"
module dacc_properties
    import dacc_pkg::*;
#(parameter int CODE_W = 8) (
    input wire logic              clk,
    input wire logic              nrst,
    input wire logic              soft_reset,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [11:0]       paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [3:0]        pstrb,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              sleep_mode,
    input wire logic              port_direction_bits,
    input wire logic [CODE_W-1:0] converter_code,
    input wire logic              converter_active,
    input wire logic [4:0]        trigger_source_out,
    input wire logic [1:0]        reference_out,
    input wire logic              analog_output_pin_oe,
    input wire logic              analog_output_to_pin,
    input wire logic              internal_output_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    logic acc;
    logic unm;
    logic wctl;
    // Access phase, unmapped decode and control write
    assign acc  = psel && penable;
    assign unm  = paddr != `DACC_CTRL_OFFSET && paddr != `DACC_DATA_OFFSET
                  && paddr != `DACC_STAT_OFFSET;
    assign wctl = acc && pwrite && paddr == `DACC_CTRL_OFFSET && !soft_reset;
    ready_now_a: assert property (acc |-> pready)
        else $error("pready low in access phase");
    unmapped_err_a: assert property (acc && unm |-> pslverr)
        else $error("no error on unmapped access");
    ctrl_fields_a: assert property (wctl && pstrb[0] |=>
        reference_out == $past(pwdata[1:0])
        && trigger_source_out == $past(pwdata[6:2]))
        else $error("select fields not stored");
    disable_off_a: assert property (wctl && pstrb[1] && !pwdata[15]
        |-> ##2 !converter_active) else $error("active after disable");
    pin_release_a: assert property (analog_output_to_pin
        |-> !analog_output_pin_oe) else $error("port drives analog pin");
    port_ctrl_a: assert property (!analog_output_to_pin
        |-> analog_output_pin_oe == !port_direction_bits)
        else $error("port enable not from direction");
    internal_out_a: assert property (
        internal_output_valid == converter_active)
        else $error("internal output mismatch");
    sleep_hold_a: assert property (sleep_mode && !soft_reset
        |=> $stable(converter_code)) else $error("code moved in sleep");
    cover property (acc && unm);
    cover property (analog_output_to_pin && sleep_mode);
    cover property (wctl && !pwdata[15]);
endmodule // dacc_properties

bind dacc_control dacc_properties #(.CODE_W(CODE_W)) u_props (.clk, .nrst,
    .soft_reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
    .pslverr, .sleep_mode, .port_direction_bits, .converter_code,
    .converter_active, .trigger_source_out, .reference_out,
    .analog_output_pin_oe, .analog_output_to_pin, .internal_output_valid);

//--- dv/dacc_pin_model.sv
// Output pin model: resolves the level seen on the converter pin
module dacc_pin_model #(parameter int CODE_W = 8) (
    input  wire logic              to_pin,
    input  wire logic [CODE_W-1:0] code,
    input  wire logic              pin_o,
    input  wire logic              pin_oe,
    output logic                   level
);
    timeunit 1ns;
    timeprecision 1ps;
    // Analog drive wins, then port drive, else weak pull-down
    always_comb begin
        if (to_pin)
            level = code[CODE_W-1];
        else if (pin_oe)
            level = pin_o;
        else
            level = 1'b0;
    end
endmodule // dacc_pin_model

//--- dv/dacc_control_tb_top.sv
// Self-checking bench for the converter control block
module dacc_control_tb_top;
    import dacc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [11:0] a; logic [31:0] w, e;} dacc_row_s;
    logic clk = 0, nrst = 0, soft_reset = 0, psel = 0, penable = 0;
    logic pwrite = 0, idle_mode = 0, sleep_mode = 0, pready, pslverr;
    logic port_direction_bits = 0, port_latch_bits = 1, level, err;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, trigger_events = 0;
    logic [3:0]  pstrb = 4'hF;
    logic [7:0]  converter_code;
    logic [4:0]  trigger_source_out;
    logic [1:0]  reference_out;
    logic converter_active, analog_output_pin_o, analog_output_pin_oe;
    logic analog_output_to_pin, internal_output_valid;
    int miscompares = 0, n_compared = 0, cycles = 0;
    dacc_row_s rows [5] = '{'{12'h000, 32'h0000_FFFF, 32'h0000_BBFF},
        '{12'h000, 32'h0000_4400, 32'h0}, '{12'h000, 32'h7F, 32'h7F},
        '{12'h004, 32'h0000_A55A, 32'h0000_A55A}, '{12'h00C, 32'h12, 32'h0}};
    dacc_control dut (.clk, .nrst, .soft_reset, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr, .idle_mode,
        .sleep_mode, .trigger_events, .port_direction_bits, .port_latch_bits,
        .converter_code, .converter_active, .trigger_source_out,
        .reference_out, .analog_output_pin_o, .analog_output_pin_oe,
        .analog_output_to_pin, .internal_output_valid);
    dacc_pin_model pin (.to_pin(analog_output_to_pin), .code(converter_code),
        .pin_o(analog_output_pin_o), .pin_oe(analog_output_pin_oe), .level);
    always #5 clk = ~clk;
    task results;
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // One APB transfer, entered just after a rising edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
             output logic [31:0] q);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask
    task srst;
        soft_reset <= 1'b1;
        tick(1);
        soft_reset <= 1'b0;
    endtask
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            results();
        end
    end
    initial begin
        tick(4);
        nrst <= 1'b1;
        tick(1);
        rd(12'h000, 32'h0);
        rd(12'h004, 32'h0);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a, rows[i].e);
        end
        chk(err, 1'b1);
        wr(12'h000, 32'h0000_8080);
        wr(12'h004, 32'h0000_12AB);
        tick(2);
        chk({analog_output_to_pin, converter_code}, 9'h1AB);
        rd(12'h008, 32'h0000_02AB);
        wr(12'h000, 32'h0000_8880);
        wr(12'h004, 32'h0000_34CD);
        tick(2);
        chk(converter_code, 8'h34);
        wr(12'h000, 32'h0000_8000);
        tick(2);
        chk({analog_output_to_pin, internal_output_valid}, 2'b01);
        wr(12'h000, 32'h0000_810C);
        wr(12'h004, 32'h0000_0055);
        tick(2);
        chk(converter_code, 8'h34);
        trigger_events[3] <= 1'b1;
        tick(1);
        trigger_events[3] <= 1'b0;
        tick(2);
        chk(converter_code, 8'h55);
        wr(12'h000, 32'h0000_9080);
        sleep_mode <= 1'b1;
        wr(12'h004, 32'h0000_0066);
        tick(2);
        chk({analog_output_to_pin, converter_code}, 9'h155);
        wr(12'h000, 32'h0000_8080);
        tick(2);
        chk({analog_output_to_pin, analog_output_pin_oe, level}, 3'b011);
        port_direction_bits <= 1'b1;
        tick(1);
        chk({analog_output_pin_oe, level}, 2'b00);
        sleep_mode <= 1'b0;
        idle_mode <= 1'b1;
        wr(12'h000, 32'h0000_8000);
        tick(2);
        chk(converter_active, 1'b1);
        wr(12'h000, 32'h0000_A000);
        tick(2);
        chk(converter_active, 1'b0);
        idle_mode <= 1'b0;
        wr(12'h000, 32'h0000_8280);
        srst();
        rd(12'h000, 32'h0000_8280);
        wr(12'h000, 32'h0000_8080);
        srst();
        rd(12'h000, 32'h0);
        rd(12'h004, 32'h0);
        wr(12'h000, 32'h0);
        tick(2);
        chk(converter_active, 1'b0);
        results();
    end
endmodule // dacc_control_tb_top
